// file: inc/eprom_pkg.sv
// Package for the UV EPROM host controller: map, timing and carrier types.
package eprom_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_RDATA  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FAIL   = 8'h14;
    // ----------------------------------------
    // Field positions of the control word
    // ----------------------------------------
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_WORD    = 4;
    localparam int CTRL_ID_SEL  = 5;
    localparam int CTRL_GO      = 8;
    // ----------------------------------------
    // Commands
    // ----------------------------------------
    localparam logic [3:0] OP_READ    = 4'h1;
    localparam logic [3:0] OP_PROGRAM = 4'h2;
    localparam logic [3:0] OP_IDENT   = 4'h3;
    localparam logic [3:0] OP_VERIFY  = 4'h4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 125;
    localparam int PULSE_US     = 100;
    localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;
    localparam int ACCESS_NS    = 100;
    localparam int ACCESS_CYC   = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC   = 2;
    localparam int MAX_PULSES   = 100;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic        strobe_n;
        logic        gate_n;
        logic        word_mode;
        logic        id_high_voltage;
        logic        prog_supply_high;
        logic        core_supply_high;
        logic        verify_supply;
    } pin_ctrl_t;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_SETUP  = 7'b0000010,
        ST_PULSE  = 7'b0000100,
        ST_GAP    = 7'b0001000,
        ST_SAMPLE = 7'b0010000,
        ST_CHECK  = 7'b0100000,
        ST_DONE   = 7'b1000000
    } state_t;
endpackage

// file: hdl/eprom_host.sv
// Host controller that drives a UV EPROM through its pins from Wishbone registers.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module eprom_host #(
    parameter int PULSE_CYCLES = eprom_pkg::PULSE_CYC,
    parameter int MAX_PULSE    = eprom_pkg::MAX_PULSES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Device pins
    output logic [17:0]      word_address_lines_o,
    output logic             byte_low_address_o,
    output logic             chip_select_program_strobe_n_o,
    output logic             output_gate_n_o,
    output logic             word_mode_o,
    output logic             identifier_high_voltage_line_o,
    output logic             prog_supply_high_o,
    output logic             core_supply_high_o,
    output logic             verify_supply_o,
    input  wire logic [15:0] data_lines_i,
    output logic [15:0]      data_lines_o,
    output logic             data_lines_oe_o
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    eprom_pkg::state_t    state_reg, state_next;
    eprom_pkg::pin_ctrl_t pins_reg;
    logic [3:0]  op_reg;
    logic        word_reg;
    logic        id_sel_reg;
    logic [18:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [18:0] fail_addr_reg;
    logic        fail_reg;
    logic        parity_ok_reg;
    logic [31:0] cnt_reg;
    logic [7:0]  pulses_reg;
    logic [15:0] s1_reg, s2_reg, s3_reg, din_reg;
    logic        ack_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    wire bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
    wire busy     = (state_reg != eprom_pkg::ST_IDLE);
    // Writes while busy are acknowledged but dropped, so a running command keeps its operands.
    wire wr_ctrl  = bus_wr && !busy && wb_adr_i == eprom_pkg::OFS_CTRL;
    wire wr_addr  = bus_wr && !busy && wb_adr_i == eprom_pkg::OFS_ADDR;
    wire wr_wdata = bus_wr && !busy && wb_adr_i == eprom_pkg::OFS_WDATA;
    wire go       = wr_ctrl && wb_dat_i[eprom_pkg::CTRL_GO];
    wire [3:0] go_op = wb_dat_i[eprom_pkg::CTRL_OP_LSB +: 4];
    wire [31:0] status_word = {28'h0, parity_ok_reg, fail_reg, state_reg == eprom_pkg::ST_DONE,
                               busy};
    assign wb_ack_o = ack_reg;

    // Odd parity over an identifier byte, with the top bit as parity bit.
    function automatic logic odd_parity(input logic [7:0] b);
        return ^b;
    endfunction

    // Word mode compares all sixteen bits; byte mode only the low byte.
    function automatic logic word_matches(input logic [15:0] got, input logic [15:0] want,
                                          input logic wmode);
        return wmode ? (got == want) : (got[7:0] == want[7:0]);
    endfunction

    // ----------------------------------------
    // Input synchroniser: a change counts once stages two and three agree
    // ----------------------------------------
    wire        sync_agree = (s2_reg == s3_reg);
    wire        is_prog    = (op_reg == eprom_pkg::OP_PROGRAM);
    wire        data_ok    = word_matches(din_reg, wdata_reg, word_reg);
    wire        pulse_end  = (cnt_reg == 32'(PULSE_CYCLES - 1));
    // The read wait spans the access time and the synchroniser, so the word has settled.
    wire        read_end   = (cnt_reg == 32'(eprom_pkg::ACCESS_CYC
                                             + eprom_pkg::SETTLE_CYC));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            eprom_pkg::ST_IDLE:   if (go) state_next = eprom_pkg::ST_SETUP;
            eprom_pkg::ST_SETUP:  state_next = is_prog ? eprom_pkg::ST_PULSE
                                                       : eprom_pkg::ST_SAMPLE;
            eprom_pkg::ST_PULSE:  if (pulse_end) state_next = eprom_pkg::ST_GAP;
            eprom_pkg::ST_GAP:    state_next = eprom_pkg::ST_SAMPLE;
            eprom_pkg::ST_SAMPLE: if (read_end) state_next = eprom_pkg::ST_CHECK;
            eprom_pkg::ST_CHECK:  begin
                if (!is_prog || data_ok || pulses_reg >= 8'(MAX_PULSE))
                    state_next = eprom_pkg::ST_DONE;
                else
                    state_next = eprom_pkg::ST_PULSE;
            end
            eprom_pkg::ST_DONE:   state_next = eprom_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        // Only the second stage reads the first; the sampled word comes from the third.
        s1_reg <= data_lines_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (sync_agree)
            din_reg <= s3_reg;
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            // Read data rides with the acknowledge, one cycle after the request is taken.
            ack_reg <= bus_req;
            unique case (wb_adr_i)
                eprom_pkg::OFS_CTRL:   wb_dat_o <= {26'h0, id_sel_reg, word_reg, op_reg};
                eprom_pkg::OFS_ADDR:   wb_dat_o <= {13'h0, addr_reg};
                eprom_pkg::OFS_WDATA:  wb_dat_o <= {16'h0, wdata_reg};
                eprom_pkg::OFS_RDATA:  wb_dat_o <= {16'h0, rdata_reg};
                eprom_pkg::OFS_STATUS: wb_dat_o <= status_word;
                eprom_pkg::OFS_FAIL:   wb_dat_o <= {13'h0, fail_addr_reg};
                default:               wb_dat_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= eprom_pkg::ST_IDLE;
            op_reg        <= eprom_pkg::OP_READ;
            word_reg      <= 1'b1;
            id_sel_reg    <= 1'b0;
            addr_reg      <= 19'h0;
            wdata_reg     <= eprom_pkg::ERASED_WORD;
            rdata_reg     <= 16'h0;
            fail_reg      <= 1'b0;
            fail_addr_reg <= 19'h0;
            parity_ok_reg <= 1'b0;
            cnt_reg       <= 32'h0;
            pulses_reg    <= 8'h0;
        end else begin
            state_reg <= state_next;
            if (wr_addr)
                addr_reg <= wb_dat_i[18:0];
            if (wr_wdata)
                wdata_reg <= wb_dat_i[15:0];
            if (go) begin
                op_reg     <= go_op;
                word_reg   <= wb_dat_i[eprom_pkg::CTRL_WORD];
                id_sel_reg <= wb_dat_i[eprom_pkg::CTRL_ID_SEL];
                fail_reg   <= 1'b0;
                pulses_reg <= 8'h0;
            end
            // Restarting on each state change makes every wait count from its entry.
            cnt_reg <= (state_next != state_reg) ? 32'h0 : cnt_reg + 32'h1;
            if (state_reg == eprom_pkg::ST_GAP)
                pulses_reg <= pulses_reg + 8'h1;
            if (state_reg == eprom_pkg::ST_CHECK) begin
                rdata_reg     <= word_reg ? din_reg : {8'h0, din_reg[7:0]};
                parity_ok_reg <= odd_parity(din_reg[7:0]);
                if (is_prog && !data_ok && pulses_reg >= 8'(MAX_PULSE)) begin
                    fail_reg      <= 1'b1;
                    fail_addr_reg <= addr_reg;
                end
            end
        end
    end

    // ----------------------------------------
    // Pin levels per state and command
    // ----------------------------------------
    wire in_pulse  = (state_reg == eprom_pkg::ST_PULSE);
    wire sampling  = (state_reg == eprom_pkg::ST_SAMPLE) || (state_reg == eprom_pkg::ST_CHECK);
    wire is_ident  = (op_reg == eprom_pkg::OP_IDENT);
    wire prog_run  = is_prog && busy && state_reg != eprom_pkg::ST_DONE;
    wire verify_op = (op_reg == eprom_pkg::OP_VERIFY);

    // Strobe, gate, mode and supply pins come from flip-flops so that no decode glitch reaches the programming strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_reg <= '{strobe_n: 1'b1, gate_n: 1'b1, word_mode: 1'b1,
                          id_high_voltage: 1'b0, prog_supply_high: 1'b0,
                          core_supply_high: 1'b0, verify_supply: 1'b0};
        end else begin
            // Programming pulses: strobe low, gate high, elevated supplies.
            // Program verify between pulses: strobe high, gate low.
            // Plain read and identifier: strobe and gate low together.
            pins_reg.strobe_n         <= !(in_pulse || (sampling && !is_prog));
            pins_reg.gate_n           <= !sampling;
            pins_reg.word_mode        <= word_reg;
            pins_reg.id_high_voltage  <= is_ident && busy;
            pins_reg.prog_supply_high <= prog_run;
            pins_reg.core_supply_high <= prog_run;
            pins_reg.verify_supply    <= verify_op && busy;
        end
    end

    // Identifier readout holds every address line low but word address line 0, which picks the code.
    assign word_address_lines_o = is_ident ? {17'h0, id_sel_reg} : addr_reg[18:1];
    assign byte_low_address_o   = is_ident ? 1'b0 : addr_reg[0];
    assign chip_select_program_strobe_n_o = pins_reg.strobe_n;
    assign output_gate_n_o                = pins_reg.gate_n;
    assign word_mode_o                    = pins_reg.word_mode;
    assign identifier_high_voltage_line_o = pins_reg.id_high_voltage;
    assign prog_supply_high_o             = pins_reg.prog_supply_high;
    assign core_supply_high_o             = pins_reg.core_supply_high;
    assign verify_supply_o                = pins_reg.verify_supply;
    // Data is driven only while the gate is high, so the host never fights the device.
    assign data_lines_o    = wdata_reg;
    assign data_lines_oe_o = is_prog && busy && pins_reg.gate_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Named steps shared by several checks.
    sequence idle_twice_s;
        state_reg == eprom_pkg::ST_IDLE ##1 state_reg == eprom_pkg::ST_IDLE;
    endsequence
    sequence sample_entry_s;
        $rose(state_reg == eprom_pkg::ST_SAMPLE);
    endsequence

    chk_prog_gate_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !chip_select_program_strobe_n_o && prog_supply_high_o |-> output_gate_n_o)
        else $error("programming strobe with gate low");
    chk_no_contention: assert property (@(posedge clk_i) disable iff (rst_i)
        data_lines_oe_o |-> output_gate_n_o)
        else $error("host drives data while gate low");
    chk_loop_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        pulses_reg <= 8'(MAX_PULSE) && (!in_pulse || pulses_reg < 8'(MAX_PULSE)))
        else $error("pulse count beyond limit");
    chk_fail_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == eprom_pkg::ST_CHECK && is_prog && !data_ok
        && pulses_reg >= 8'(MAX_PULSE) |=> fail_reg)
        else $error("failure not flagged");
    chk_core_supply: assert property (@(posedge clk_i) disable iff (rst_i)
        in_pulse |-> ##1 core_supply_high_o)
        else $error("core supply low during pulse");
    chk_ident_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        identifier_high_voltage_line_o |-> word_address_lines_o[17:1] == 17'h0)
        else $error("address lines not low in identifier mode");
    chk_verify_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state_reg == eprom_pkg::ST_SAMPLE) && is_prog |=> chip_select_program_strobe_n_o
        && !output_gate_n_o)
        else $error("verify pin levels wrong");
    chk_idle_standby: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_twice_s |-> chip_select_program_strobe_n_o)
        else $error("strobe low while idle");
    chk_read_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_entry_s ##0 !is_prog |=> !chip_select_program_strobe_n_o
        && !output_gate_n_o)
        else $error("read pin levels wrong");
    chk_ident_level: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_entry_s ##0 is_ident |-> identifier_high_voltage_line_o)
        else $error("identifier level missing while sampling");
    chk_idle_supplies: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_twice_s |-> !prog_supply_high_o && !core_supply_high_o && !data_lines_oe_o)
        else $error("supplies or data left on while idle");
    chk_verify_levels: assert property (@(posedge clk_i) disable iff (rst_i)
        verify_supply_o |-> !prog_supply_high_o && !core_supply_high_o)
        else $error("verify level with raised supplies");
    chk_pulse_data: assert property (@(posedge clk_i) disable iff (rst_i)
        !chip_select_program_strobe_n_o && prog_supply_high_o |-> data_lines_oe_o)
        else $error("program strobe without data driven");
    chk_fail_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        go |=> !fail_reg)
        else $error("failure flag not cleared by new command");
endmodule

// file: dv/eprom_device_model.sv
// Behavioural pin-level model of the UV EPROM.
`timescale 1ns/1ps
module eprom_device_model #(
    parameter logic [7:0] MAKER_ID  = 8'h07, // Arbitrary value with odd parity.
    parameter logic [7:0] DEVICE_ID = 8'h0B  // Arbitrary value with odd parity.
) (
    // Device pins
    input  wire logic [17:0] addr_i,
    input  wire logic        byte_low_i,
    input  wire logic        strobe_n_i,
    input  wire logic        gate_n_i,
    input  wire logic        word_mode_i,
    input  wire logic        id_hv_i,
    input  wire logic        prog_hv_i,
    input  wire logic [15:0] din_i,
    // Scenario control, then the data output lines
    input  wire logic        stuck_i,
    output logic      [15:0] dq_o
);
    // ----
    // Array and readout
    // ----
    // Only sixteen words are kept; upper address bits alias to keep it small.
    logic [15:0] mem [0:15];
    logic [15:0] word_q;
    logic [15:0] last_q;
    wire         drive = !gate_n_i && (!strobe_n_i || prog_hv_i);
    wire  [7:0]  id_b  = addr_i[0] ? DEVICE_ID : MAKER_ID;
    initial begin
        last_q = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'hFFFF;
        end
    end
    // Level sensitive, so the order in which host pins settle does not matter.
    always @(strobe_n_i, gate_n_i, prog_hv_i, din_i, addr_i, stuck_i) begin
        if (!strobe_n_i && gate_n_i && prog_hv_i && !stuck_i) begin
            mem[addr_i[3:0]] = mem[addr_i[3:0]] & din_i;
        end
    end
    always_comb begin
        word_q = mem[addr_i[3:0]];
        if (id_hv_i) begin
            word_q = {~last_q[15:8], id_b};
        end else if (!word_mode_i) begin
            word_q = {~last_q[15:8], byte_low_i ? word_q[15:8] : word_q[7:0]};
        end
    end
    always @(negedge drive) begin
        last_q = word_q;
    end
    // Released lines show the inverse of the last value, never a stale copy.
    assign dq_o = drive ? word_q : ~last_q;
endmodule

// file: dv/eprom_host_bench.sv
// Self-checking bench for the EPROM host controller against the device model.
`timescale 1ns/1ps
module eprom_host_bench;
    localparam logic [7:0] MK = 8'h07; // Arbitrary value with odd parity.
    localparam logic [7:0] DV = 8'h0B; // Arbitrary value with odd parity.
    logic        clk_i;
    logic        rst_i = 1'h1;
    logic        cyc   = 1'h0;
    logic        stb   = 1'h0;
    logic        we    = 1'h0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic        stuck = 1'h0;
    logic        pprev = 1'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [17:0] wal;
    logic        bla;
    logic        cs_n;
    logic        oe_n;
    logic        wm;
    logic        idhv;
    logic        psh;
    logic        csh;
    logic        vsup;
    logic [15:0] hq;
    logic        hoe;
    logic [15:0] dq;
    int          pulses = 0;
    int          vs_hits = 0;
    int          p0;
    int          miscompares = 0;
    int          comparisons = 0;
    wire  [15:0] bus  = hoe ? hq : dq;
    wire         pnow = !cs_n && oe_n && psh && csh;
    eprom_host #(.PULSE_CYCLES(4), .MAX_PULSE(3)) u_eprom_host (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .word_address_lines_o(wal), .byte_low_address_o(bla),
        .chip_select_program_strobe_n_o(cs_n), .output_gate_n_o(oe_n), .word_mode_o(wm),
        .identifier_high_voltage_line_o(idhv), .prog_supply_high_o(psh),
        .core_supply_high_o(csh), .verify_supply_o(vsup), .data_lines_i(bus),
        .data_lines_o(hq), .data_lines_oe_o(hoe));
    eprom_device_model #(.MAKER_ID(MK), .DEVICE_ID(DV)) u_eprom_device_model (
        .addr_i(wal), .byte_low_i(bla), .strobe_n_i(cs_n), .gate_n_i(oe_n),
        .word_mode_i(wm), .id_hv_i(idhv), .prog_hv_i(psh), .din_i(bus),
        .stuck_i(stuck), .dq_o(dq));
    // ----
    // Clock, monitors and tasks
    // ----
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    // Counts program pulses taken with the core supply raised.
    always @(posedge clk_i) begin
        pprev <= pnow;
        if (pnow && !pprev) pulses <= pulses + 1;
        if (vsup === 1'h1) vs_hits <= vs_hits + 1;
    end
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
        if (ack !== 1'h1) begin
            chk("bus ack", 32'h1, 32'h0);
            tally_and_finish();
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'h0, a, 32'h0, q);
        chk(what, exp, q & m);
    endtask
    // Loads address and data, starts the command, then polls busy to zero.
    task automatic run(input logic [3:0] op, input logic wd, input logic ids,
                       input logic [18:0] ba, input logic [15:0] d);
        logic [31:0] q;
        int n;
        n = 0;
        xfer(1'h1, eprom_pkg::OFS_ADDR, {13'h0, ba}, q);
        xfer(1'h1, eprom_pkg::OFS_WDATA, {16'h0, d}, q);
        xfer(1'h1, eprom_pkg::OFS_CTRL, {23'h0, 1'h1, 2'h0, ids, wd, op}, q);
        do begin
            xfer(1'h0, eprom_pkg::OFS_STATUS, 32'h0, q);
            n++;
        end while (q[0] !== 1'h0 && n < 100);
        if (q[0] !== 1'h0) begin
            chk("busy cleared", 32'h0, {31'h0, q[0]});
            tally_and_finish();
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        rchk("status after reset", eprom_pkg::OFS_STATUS, 32'h5, 32'h0);
        chk("idle pins", 32'h6, {29'h0, cs_n, oe_n, hoe});
        rchk("unmapped read", 8'h18, 32'hFFFFFFFF, 32'h0);
        $display("Done: reset and map");
        run(eprom_pkg::OP_READ, 1'h1, 1'h0, 19'h10, 16'h0);
        rchk("erased word", eprom_pkg::OFS_RDATA, 32'hFFFFFFFF, 32'hFFFF);
        p0 = pulses;
        run(eprom_pkg::OP_PROGRAM, 1'h1, 1'h0, 19'h4, 16'h1234);
        chk("pulse count", 32'h1, 32'(pulses - p0));
        rchk("program fail", eprom_pkg::OFS_STATUS, 32'h4, 32'h0);
        run(eprom_pkg::OP_READ, 1'h1, 1'h0, 19'h4, 16'h0);
        rchk("word read", eprom_pkg::OFS_RDATA, 32'hFFFFFFFF, 32'h1234);
        run(eprom_pkg::OP_READ, 1'h0, 1'h0, 19'h4, 16'h0);
        rchk("low byte", eprom_pkg::OFS_RDATA, 32'hFFFFFFFF, 32'h34);
        run(eprom_pkg::OP_READ, 1'h0, 1'h0, 19'h5, 16'h0);
        rchk("high byte", eprom_pkg::OFS_RDATA, 32'hFFFFFFFF, 32'h12);
        $display("Done: program and read");
        run(eprom_pkg::OP_PROGRAM, 1'h1, 1'h0, 19'h4, 16'h00FF);
        chk("verify supply idle", 32'h0, 32'(vs_hits));
        run(eprom_pkg::OP_VERIFY, 1'h1, 1'h0, 19'h4, 16'h0);
        rchk("clear only", eprom_pkg::OFS_RDATA, 32'hFFFF, 32'h0034);
        chk("verify supply used", 32'h1, {31'h0, vs_hits > 0});
        $display("Done: reprogram and verify");
        run(eprom_pkg::OP_IDENT, 1'h0, 1'h0, 19'h0, 16'h0);
        rchk("maker code", eprom_pkg::OFS_RDATA, 32'hFF, {24'h0, MK});
        rchk("maker parity", eprom_pkg::OFS_STATUS, 32'h8, 32'h8);
        run(eprom_pkg::OP_IDENT, 1'h0, 1'h1, 19'h0, 16'h0);
        rchk("device code", eprom_pkg::OFS_RDATA, 32'hFF, {24'h0, DV});
        rchk("device parity", eprom_pkg::OFS_STATUS, 32'h8, 32'h8);
        rchk("control readback", eprom_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h23);
        $display("Done: identifier");
        @(posedge clk_i);
        stuck <= 1'h1;
        p0 = pulses;
        run(eprom_pkg::OP_PROGRAM, 1'h1, 1'h0, 19'h10, 16'h0);
        chk("pulse limit", 32'h3, 32'(pulses - p0));
        rchk("fail flag", eprom_pkg::OFS_STATUS, 32'h4, 32'h4);
        rchk("fail address", eprom_pkg::OFS_FAIL, 32'hFFFFFFFF, 32'h10);
        rchk("address readback", eprom_pkg::OFS_ADDR, 32'hFFFFFFFF, 32'h10);
        $display("Done: pulse limit");
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        chk("run time", 32'h0, 32'h1);
        tally_and_finish();
    end
endmodule
